// ===== verilog/sdram_pkg.sv
// Constants, types and command decoding for the DRAM timing core
// How it works
// - Read or write column commands may be issued on every clock.
// - Clock enable sampled low suspends or powers down one clock later.
// - Clock enable sampled high resumes operation one clock later.
// - Write data mask acts on the data word of the same clock.
// - Read data mask floats the matching output byte two clocks later.
// - Precharge during read floats outputs after 3 clocks (latency 3), 2 (latency 2).
// - Auto precharge starts 7.5ns after the first clock past last write.
package sdram_pkg;

   // Widths of the pins and of the small storage array
   localparam int DQ_W = 16;
   localparam int LANES = 2;
   localparam int BA_W = 2;
   localparam int ADDR_W = 13;
   localparam int COL_W = 2;
   localparam int IDX_W = BA_W + COL_W;
   localparam int WORDS = 16;
   localparam int BANKS = 4;
   localparam int CNT_W = 4;

   // Timing in picoseconds and derived cycle counts at 125 MHz
   localparam int CLK_PERIOD_PS = 8000;
   localparam int WR_AP_DELAY_PS = 7500;
   localparam int ROW_CLOSE_PERIOD_PS = 20000;
   localparam int REFRESH_PS = 70000;
   localparam int AP_DELAY_CYC =
      1 + (WR_AP_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ROW_CLOSE_CYC =
      (ROW_CLOSE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int REFRESH_CYC =
      (REFRESH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [CNT_W-1:0] AP_DELAY_CNT = CNT_W'(AP_DELAY_CYC);
   localparam logic [CNT_W-1:0] ROW_CLOSE_CNT = CNT_W'(ROW_CLOSE_CYC);
   localparam logic [CNT_W-1:0] REFRESH_CNT = CNT_W'(REFRESH_CYC);

   // Mode word fields, address bits and reset values
   localparam int MODE_BL_LSB = 0;
   localparam int MODE_CL_LSB = 4;
   localparam int AP_ADDR_BIT = 10;
   localparam logic [2:0] MODE_BL_RST = 3'h0;
   localparam logic [2:0] MODE_CL_RST = 3'h3;
   localparam logic [2:0] CL_TWO = 3'h2;
   localparam logic [1:0] INIT_REF_CNT = 2'h2;

   // Power state of the core, one-hot
   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_SUSPEND = 3'b010,
      ST_PDOWN = 3'b100
   } pwr_state_t;

   typedef enum logic [2:0] {
      CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS, CMD_BST
   } cmd_t;

   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } cmd_pins_t;

   typedef struct packed {
      logic [IDX_W-1:0] idx;
      logic [DQ_W-1:0] data;
      logic [LANES-1:0] mask;
   } wr_word_t;

   typedef struct packed {
      logic valid;
      logic [IDX_W-1:0] idx;
   } rd_slot_t;

   // Command pins to command, sampled on the rising edge
   function automatic cmd_t cmd_decode(cmd_pins_t p);
      cmd_t c;
      c = CMD_NOP;
      if (!p.cs_n) begin
         case ({p.ras_n, p.cas_n, p.we_n})
            3'h0: c = CMD_MRS;
            3'h1: c = CMD_REF;
            3'h2: c = CMD_PRE;
            3'h3: c = CMD_ACT;
            3'h4: c = CMD_WR;
            3'h5: c = CMD_RD;
            3'h6: c = CMD_BST;
            default: c = CMD_NOP;
         endcase
      end
      return c;
   endfunction

endpackage

// ===== verilog/word_buf2.sv
// Two-entry buffer between the write pins and the storage array
`timescale 1ns/1ns
module word_buf2 #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);

   logic [W-1:0] ent_r [2];
   logic wr_ptr_r;
   logic rd_ptr_r;
   logic [1:0] count_r;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   // Full and empty from the occupancy count
   assign in_ready = (count_r != 2'h2);
   assign out_valid = (count_r != 2'h0);
   assign out_data = ent_r[rd_ptr_r];

   // Pointers and count
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r <= 2'h0;
      end else begin
         if (push) wr_ptr_r <= ~wr_ptr_r;
         if (pop) rd_ptr_r <= ~rd_ptr_r;
         if (push && !pop) count_r <= count_r + 2'h1;
         else if (pop && !push) count_r <= count_r - 2'h1;
      end
   end

   // Entry storage
   always_ff @(posedge core_clk) begin
      if (push) ent_r[wr_ptr_r] <= in_data;
   end

endmodule

// ===== verilog/sdram_timing_core.sv
// Command sequencing, data path and power states of the DRAM core
`timescale 1ns/1ns
module sdram_timing_core (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Registered command inputs
   input wire logic cke,
   input wire sdram_pkg::cmd_pins_t cmd_pins,
   input wire logic [sdram_pkg::BA_W-1:0] ba,
   input wire logic [sdram_pkg::ADDR_W-1:0] addr,
   input wire logic [sdram_pkg::LANES-1:0] dqm,
   // Data pins as input, output and per-lane enable
   input wire logic [sdram_pkg::DQ_W-1:0] dq_i,
   output logic [sdram_pkg::DQ_W-1:0] dq_o,
   output logic [sdram_pkg::LANES-1:0] dq_oe,
   // Status
   output logic power_down,
   output logic suspended,
   output logic [sdram_pkg::BANKS-1:0] bank_open,
   output logic init_done,
   output logic wr_accept
);

   sdram_pkg::pwr_state_t state_r;
   sdram_pkg::pwr_state_t state_nxt;
   sdram_pkg::cmd_t cmd;
   sdram_pkg::rd_slot_t rd_pipe0_r;
   sdram_pkg::rd_slot_t rd_pipe1_r;
   sdram_pkg::rd_slot_t tap;
   sdram_pkg::wr_word_t buf_in;
   sdram_pkg::wr_word_t buf_out;
   logic [2:0] mode_bl_r;
   logic [2:0] mode_cl_r;
   logic [sdram_pkg::CNT_W-1:0] burst_left_r;
   logic [sdram_pkg::CNT_W-1:0] bl_len;
   logic [sdram_pkg::COL_W-1:0] col_r;
   logic [sdram_pkg::BA_W-1:0] bnk_r;
   logic burst_wr_r;
   logic burst_ap_r;
   logic [sdram_pkg::LANES-1:0] dqm_d1_r;
   logic [sdram_pkg::DQ_W-1:0] dq_o_r;
   logic [sdram_pkg::LANES-1:0] dq_oe_r;
   logic [sdram_pkg::DQ_W-1:0] mem_r [sdram_pkg::WORDS];
   logic [sdram_pkg::BANKS-1:0] bank_open_r;
   logic [sdram_pkg::BANKS-1:0] bank_open_nxt;
   logic [sdram_pkg::CNT_W-1:0] ap_wait_r;
   logic [sdram_pkg::CNT_W-1:0] ap_close_r;
   logic [sdram_pkg::BA_W-1:0] ap_bank_r;
   logic [sdram_pkg::CNT_W-1:0] ref_busy_r;
   logic [1:0] ref_count_r;
   logic buf_out_valid;
   logic [sdram_pkg::IDX_W-1:0] cmd_idx;
   logic [sdram_pkg::IDX_W-1:0] iss_idx;

   // Command decode; nothing is taken while the clock is suspended
   wire active = (state_r == sdram_pkg::ST_RUN);
   assign cmd = sdram_pkg::cmd_decode(cmd_pins);
   wire act_go = active && (cmd == sdram_pkg::CMD_ACT);
   wire rd_go = active && (cmd == sdram_pkg::CMD_RD);
   wire wr_go = active && (cmd == sdram_pkg::CMD_WR);
   wire pre_go = active && (cmd == sdram_pkg::CMD_PRE);
   wire ref_go = active && (cmd == sdram_pkg::CMD_REF);
   wire mrs_go = active && (cmd == sdram_pkg::CMD_MRS);
   wire bst_go = active && (cmd == sdram_pkg::CMD_BST);
   wire cmd_taken = active && (cmd != sdram_pkg::CMD_NOP);

   // Column issue: a new column command preempts the running burst
   assign bl_len = sdram_pkg::CNT_W'(4'h1 << mode_bl_r[1:0]);
   assign cmd_idx = {ba, addr[sdram_pkg::COL_W-1:0]};
   wire col_cmd = rd_go || wr_go;
   wire stop = bst_go || pre_go;
   wire cont = active && (burst_left_r != '0) && !stop && !col_cmd;
   wire issue = col_cmd || cont;
   wire is_wr = col_cmd ? wr_go : burst_wr_r;
   wire ap_flag = col_cmd ? addr[sdram_pkg::AP_ADDR_BIT] : burst_ap_r;
   assign iss_idx = col_cmd ? cmd_idx : {bnk_r, col_r};
   wire last_beat = col_cmd ? (bl_len == 4'h1) : (burst_left_r == 4'h1);
   wire ap_arm = issue && is_wr && ap_flag && last_beat;
   wire busy = (burst_left_r != '0) || rd_pipe0_r.valid || rd_pipe1_r.valid;

   // Power state follows clock enable one clock later
   assign state_nxt = cke ? sdram_pkg::ST_RUN :
      (busy ? sdram_pkg::ST_SUSPEND : sdram_pkg::ST_PDOWN);

   // Read data tap selected by the read latency
   wire cl2 = (mode_cl_r == sdram_pkg::CL_TWO);
   assign tap = cl2 ? rd_pipe0_r : rd_pipe1_r;

   // Write words carry their own mask and the data of the same clock
   wire wr_push = issue && is_wr;
   assign buf_in = '{idx: iss_idx, data: dq_i, mask: dqm};
   wire array_ready = (ref_busy_r == '0);
   wire pop = buf_out_valid && array_ready;

   word_buf2 #(
      .W($bits(sdram_pkg::wr_word_t))
   ) u_wr_buf (
      .core_clk(core_clk),
      .rstn(rstn),
      .in_valid(wr_push),
      .in_ready(wr_accept),
      .in_data(buf_in),
      .out_valid(buf_out_valid),
      .out_ready(array_ready),
      .out_data(buf_out)
   );

   // Power state and burst progress
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= sdram_pkg::ST_RUN;
         burst_left_r <= '0;
         col_r <= '0;
         bnk_r <= '0;
         burst_wr_r <= 1'b0;
         burst_ap_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (col_cmd) begin
            burst_left_r <= bl_len - 4'h1;
            col_r <= addr[sdram_pkg::COL_W-1:0] + 2'h1;
            bnk_r <= ba;
            burst_wr_r <= wr_go;
            burst_ap_r <= addr[sdram_pkg::AP_ADDR_BIT];
         end else if (stop) begin
            burst_left_r <= '0;
         end else if (cont) begin
            burst_left_r <= burst_left_r - 4'h1;
            col_r <= col_r + 2'h1;
         end
      end
   end

   // Mode word: burst length and read latency
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mode_bl_r <= sdram_pkg::MODE_BL_RST;
         mode_cl_r <= sdram_pkg::MODE_CL_RST;
      end else if (mrs_go) begin
         mode_bl_r <= addr[sdram_pkg::MODE_BL_LSB +: 3];
         mode_cl_r <= addr[sdram_pkg::MODE_CL_LSB +: 3];
      end
   end

   // Read pipeline, data mask delay and output drive; frozen in suspend
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rd_pipe0_r <= '0;
         rd_pipe1_r <= '0;
         dqm_d1_r <= '0;
         dq_o_r <= '0;
         dq_oe_r <= '0;
      end else if (active) begin
         rd_pipe0_r <= '{valid: issue && !is_wr, idx: iss_idx};
         rd_pipe1_r <= rd_pipe0_r;
         dqm_d1_r <= dqm;
         dq_o_r <= mem_r[tap.idx];
         dq_oe_r <= {sdram_pkg::LANES{tap.valid}} & ~dqm_d1_r;
      end
   end

   // Array write; masked lanes keep their old contents
   always_ff @(posedge core_clk) begin
      if (pop) begin
         for (int l = 0; l < sdram_pkg::LANES; l++) begin
            if (!buf_out.mask[l]) begin
               mem_r[buf_out.idx][l*8 +: 8] <= buf_out.data[l*8 +: 8];
            end
         end
      end
   end

   // Open banks: activate wins over a close in the same clock
   always_comb begin
      bank_open_nxt = bank_open_r;
      if (ap_close_r == 4'h1) bank_open_nxt[ap_bank_r] = 1'b0;
      if (pre_go && addr[sdram_pkg::AP_ADDR_BIT]) bank_open_nxt = '0;
      else if (pre_go) bank_open_nxt[ba] = 1'b0;
      if (act_go) bank_open_nxt[ba] = 1'b1;
   end

   // Self-timed precharge after an auto-precharged write, and refresh
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         bank_open_r <= '0;
         ap_wait_r <= '0;
         ap_close_r <= '0;
         ap_bank_r <= '0;
         ref_busy_r <= '0;
         ref_count_r <= 2'h0;
      end else begin
         bank_open_r <= bank_open_nxt;
         if (ap_arm) begin
            ap_wait_r <= sdram_pkg::AP_DELAY_CNT;
            ap_bank_r <= col_cmd ? ba : bnk_r;
         end else if (ap_wait_r != '0) begin
            ap_wait_r <= ap_wait_r - 4'h1;
         end
         if (ap_wait_r == 4'h1) ap_close_r <= sdram_pkg::ROW_CLOSE_CNT;
         else if (ap_close_r != '0) ap_close_r <= ap_close_r - 4'h1;
         if (ref_go) ref_busy_r <= sdram_pkg::REFRESH_CNT;
         else if (ref_busy_r != '0) ref_busy_r <= ref_busy_r - 4'h1;
         if (ref_go && ref_count_r != sdram_pkg::INIT_REF_CNT)
            ref_count_r <= ref_count_r + 2'h1;
      end
   end

   // Outputs
   assign dq_o = dq_o_r;
   assign dq_oe = dq_oe_r;
   assign power_down = (state_r == sdram_pkg::ST_PDOWN);
   assign suspended = (state_r == sdram_pkg::ST_SUSPEND);
   assign bank_open = bank_open_r;
   assign init_done = (ref_count_r == sdram_pkg::INIT_REF_CNT);

   // Snapshot of the word being written, for the mask check
   logic [sdram_pkg::IDX_W-1:0] chk_idx_r;
   logic [7:0] chk_old_r;
   logic [7:0] chk_new_r;
   logic chk_mask_r;
   always_ff @(posedge core_clk) begin
      chk_idx_r <= buf_out.idx;
      chk_old_r <= mem_r[buf_out.idx][7:0];
      chk_new_r <= buf_out.data[7:0];
      chk_mask_r <= buf_out.mask[0];
   end
   wire [7:0] chk_now = mem_r[chk_idx_r][7:0];

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   // The second of two back-to-back reads reaches the read pipeline
   property p_col_back_to_back;
      rd_go ##1 rd_go |=> rd_pipe0_r.valid && rd_pipe0_r.idx == $past(cmd_idx);
   endproperty
   a_col_back_to_back: assert property (p_col_back_to_back)
      else $error("second back-to-back read not issued");

   // Clock enable low blocks commands, then the burst stays frozen
   property p_cke_entry;
      cke ##1 !cke |=> !cmd_taken ##1 $stable(burst_left_r);
   endproperty
   a_cke_entry: assert property (p_cke_entry)
      else $error("command taken after clock enable went low");

   // Clock enable high resumes operation exactly one clock later
   property p_cke_exit;
      $rose(cke) |-> !active ##1 active;
   endproperty
   a_cke_exit: assert property (p_cke_exit)
      else $error("resume latency after clock enable is not one clock");

   // Masked byte keeps its value, unmasked byte takes the new data
   property p_wr_mask;
      pop |=> chk_now == (chk_mask_r ? chk_old_r : chk_new_r);
   endproperty
   a_wr_mask: assert property (p_wr_mask)
      else $error("write mask not applied to low byte");

   // Read mask floats the low lane two clocks after sampling
   property p_rd_mask;
      (active && dqm[0]) ##1 active |=> !dq_oe[0];
   endproperty
   a_rd_mask: assert property (p_rd_mask)
      else $error("low lane driven two clocks after read mask");

   // Precharge with latency three floats outputs three clocks later
   property p_pre_off_cl3;
      (pre_go && !cl2) ##1 (active && !rd_go)[*2] |=> dq_oe == '0;
   endproperty
   a_pre_off_cl3: assert property (p_pre_off_cl3)
      else $error("outputs driven three clocks after precharge");

   // Precharge with latency two floats outputs two clocks later
   property p_pre_off_cl2;
      (pre_go && cl2) ##1 (active && !rd_go) |=> dq_oe == '0;
   endproperty
   a_pre_off_cl2: assert property (p_pre_off_cl2)
      else $error("outputs driven two clocks after precharge");

   // Internal precharge starts at the second edge after the last write
   property p_ap_start;
      ap_arm ##1 (!ap_arm)[*2] |=> ap_close_r == sdram_pkg::ROW_CLOSE_CNT;
   endproperty
   a_ap_start: assert property (p_ap_start)
      else $error("auto precharge did not start on time");

endmodule

// ===== testbench/ctl_model.sv
// Controller model driving the core's command, mask and data pins
`timescale 1ns/1ns
module ctl_model (
   // Clock
   input wire logic core_clk,
   // Command side
   output logic cke,
   output sdram_pkg::cmd_pins_t cmd_pins,
   output logic [sdram_pkg::BA_W-1:0] ba,
   output logic [sdram_pkg::ADDR_W-1:0] addr,
   output logic [sdram_pkg::LANES-1:0] dqm,
   // Write data
   output logic [sdram_pkg::DQ_W-1:0] dq_i
);
   localparam int PAUSE_CYC = 12500; // 100us at 8ns

   // Idle pins at time zero
   initial begin
      cke = 1'b1;
      cmd_pins = 4'hf;
      ba = 2'h0;
      addr = 13'h0000;
      dqm = 2'h0;
      dq_i = 16'h0000;
   end

   // One command per edge; the data bus flips when it carries nothing
   task automatic cmd(input sdram_pkg::cmd_t c, input logic [1:0] b,
      input logic [12:0] a, input logic [15:0] d, input logic [1:0] m);
      @(posedge core_clk);
      case (c)
         sdram_pkg::CMD_MRS: cmd_pins <= 4'h0;
         sdram_pkg::CMD_REF: cmd_pins <= 4'h1;
         sdram_pkg::CMD_PRE: cmd_pins <= 4'h2;
         sdram_pkg::CMD_ACT: cmd_pins <= 4'h3;
         sdram_pkg::CMD_WR: cmd_pins <= 4'h4;
         sdram_pkg::CMD_RD: cmd_pins <= 4'h5;
         sdram_pkg::CMD_BST: cmd_pins <= 4'h6;
         default: cmd_pins <= 4'hf;
      endcase
      ba <= b;
      addr <= a;
      dqm <= m;
      dq_i <= (c == sdram_pkg::CMD_WR) ? d : ~dq_i;
   endtask

   // Deselected cycles with a chosen mask
   task automatic idle(input int k, input logic [1:0] m);
      repeat (k) begin
         @(posedge core_clk);
         cmd_pins <= 4'hf;
         dqm <= m;
         dq_i <= ~dq_i;
      end
   endtask

   // Clock enable change on a quiet cycle
   task automatic set_cke(input logic v);
      @(posedge core_clk);
      cmd_pins <= 4'hf;
      cke <= v;
   endtask

   // Two refreshes that wake the array, after power-up or a missed interval
   task automatic wake;
      cmd(sdram_pkg::CMD_REF, 2'h0, 13'h0000, 16'h0000, 2'h0);
      idle(8, 2'h0);
      cmd(sdram_pkg::CMD_REF, 2'h0, 13'h0000, 16'h0000, 2'h0);
   endtask

   // Power-up pause, then the wake-up refreshes
   task automatic power_up;
      idle(PAUSE_CYC, 2'h0);
      wake;
   endtask

   // Mode load followed by its recovery gap
   task automatic mode(input logic [12:0] a);
      cmd(sdram_pkg::CMD_MRS, 2'h0, a, 16'h0000, 2'h0);
      idle(2, 2'h0);
   endtask

   // Precharge kept clear of the last write word
   task automatic close(input logic [1:0] b, input logic all);
      idle(2, 2'h0);
      cmd(sdram_pkg::CMD_PRE, b, {2'h0, all, 10'h000}, 16'h0000, 2'h0);
   endtask

   // Activate after a wait, then the row-to-column gap
   task automatic open(input logic [1:0] b, input int w);
      idle(w, 2'h0);
      cmd(sdram_pkg::CMD_ACT, b, 13'h0000, 16'h0000, 2'h0);
      idle(2, 2'h0);
   endtask
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the DRAM timing core
`timescale 1ns/1ns
module tb_top;
   localparam sdram_pkg::cmd_t RD = sdram_pkg::CMD_RD;
   localparam sdram_pkg::cmd_t WR = sdram_pkg::CMD_WR;
   logic core_clk;
   logic rstn;
   logic cke;
   sdram_pkg::cmd_pins_t cmd_pins;
   logic [sdram_pkg::BA_W-1:0] ba;
   logic [sdram_pkg::ADDR_W-1:0] addr;
   logic [sdram_pkg::LANES-1:0] dqm;
   logic [sdram_pkg::DQ_W-1:0] dq_i;
   logic [sdram_pkg::DQ_W-1:0] dq_o;
   logic [sdram_pkg::LANES-1:0] dq_oe;
   logic power_down;
   logic suspended;
   logic [sdram_pkg::BANKS-1:0] bank_open;
   logic init_done;
   logic wr_accept;
   int err_count = 0;
   int comparisons = 0;

   // Fixed-rate clock
   initial core_clk = 1'b0;
   always #4 core_clk = ~core_clk;

   ctl_model u_ctl (.core_clk(core_clk), .cke(cke), .cmd_pins(cmd_pins),
      .ba(ba), .addr(addr), .dqm(dqm), .dq_i(dq_i));

   sdram_timing_core u_dut (.core_clk(core_clk), .rstn(rstn), .cke(cke),
      .cmd_pins(cmd_pins), .ba(ba), .addr(addr), .dqm(dqm), .dq_i(dq_i),
      .dq_o(dq_o), .dq_oe(dq_oe), .power_down(power_down),
      .suspended(suspended), .bank_open(bank_open),
      .init_done(init_done), .wr_accept(wr_accept));

   // Compare and count
   task automatic check(input string nm, input logic [15:0] seen,
      input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Run k quiet edges, then settle at the falling edge
   task automatic look(input int k, input logic [1:0] m);
      u_ctl.idle(k, m);
      @(negedge core_clk);
   endtask

   task automatic stop_test;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Outputs while reset is held
   task automatic t_reset;
      @(negedge core_clk);
      check("oe", dq_oe, 2'h0);
      check("dq_o", dq_o, 16'h0000);
      check("pd", power_down, 1'b0);
      check("susp", suspended, 1'b0);
      check("open", bank_open, 4'h0);
      check("init", init_done, 1'b0);
      check("wacc", wr_accept, 1'b1);
   endtask

   // Full then masked write back to back, read back at latency three
   task automatic t_wr_rd;
      u_ctl.open(2'h1, 0);
      u_ctl.cmd(WR, 2'h1, 13'h0000, 16'h1234, 2'h0);
      u_ctl.cmd(WR, 2'h1, 13'h0000, 16'habcd, 2'h1);
      u_ctl.idle(1, 2'h0);
      u_ctl.cmd(RD, 2'h1, 13'h0000, 16'h0000, 2'h0);
      look(3, 2'h0);
      check("rd_data", dq_o, 16'hab34);
      check("rd_oe", dq_oe, 2'h3);
      look(1, 2'h0);
      check("rd_end", dq_oe, 2'h0);
   endtask

   // Read mask one edge after the read floats lane 0 on the data cycle
   task automatic t_rd_mask;
      u_ctl.cmd(RD, 2'h1, 13'h0000, 16'h0000, 2'h0);
      look(1, 2'h1);
      look(2, 2'h0);
      check("mask_oe", dq_oe, 2'h2);
      check("mask_hi", dq_o[15:8], 8'hab);
   endtask

   // Burst of eight cut by precharge one edge after the read
   task automatic t_pre_cut(input logic [2:0] cl);
      u_ctl.close(2'h0, 1'b1);
      u_ctl.mode({6'h00, cl, 1'b0, 3'h3});
      u_ctl.open(2'h2, 0);
      u_ctl.cmd(RD, 2'h2, 13'h0000, 16'h0000, 2'h0);
      u_ctl.cmd(sdram_pkg::CMD_PRE, 2'h2, 13'h0000, 16'h0000, 2'h0);
      look(int'(cl) - 1, 2'h0);
      check("cut_on", dq_oe, 2'h3);
      look(1, 2'h0);
      check("cut_off", dq_oe, 2'h0);
      check("cut_bank", bank_open[2], 1'b0);
   endtask

   // Power-down ignores commands; one quiet edge after exit they count
   task automatic t_cke;
      u_ctl.set_cke(1'b0);
      u_ctl.cmd(sdram_pkg::CMD_ACT, 2'h3, 13'h0000, 16'h0000, 2'h0);
      look(2, 2'h0);
      check("pd_on", power_down, 1'b1);
      check("pd_act", bank_open[3], 1'b0);
      u_ctl.set_cke(1'b1);
      u_ctl.cmd(sdram_pkg::CMD_ACT, 2'h3, 13'h0000, 16'h0000, 2'h0);
      look(1, 2'h0);
      check("pd_off", power_down, 1'b0);
      check("pd_open", bank_open[3], 1'b1);
   endtask

   // Write with auto precharge closes the bank on the fixed delay
   task automatic t_autopre;
      u_ctl.open(2'h0, 0);
      u_ctl.cmd(WR, 2'h0, 13'h0401, 16'h5a5a, 2'h0);
      look(5, 2'h0);
      check("ap_hold", bank_open[0], 1'b1);
      look(1, 2'h0);
      check("ap_shut", bank_open[0], 1'b0);
      u_ctl.open(2'h0, 5);
      u_ctl.cmd(RD, 2'h0, 13'h0001, 16'h0000, 2'h0);
      look(3, 2'h0);
      check("ap_data", dq_o, 16'h5a5a);
   endtask

   // Refresh stalls the array; buffer fills, drains, nothing lost
   task automatic t_buffer;
      u_ctl.cmd(sdram_pkg::CMD_REF, 2'h0, 13'h0000, 16'h0000, 2'h0);
      u_ctl.open(2'h1, 0);
      u_ctl.cmd(WR, 2'h1, 13'h0001, 16'hc3c3, 2'h0);
      u_ctl.cmd(WR, 2'h1, 13'h0002, 16'h3c3c, 2'h0);
      look(1, 2'h0);
      check("buf_full", wr_accept, 1'b0);
      look(8, 2'h0);
      check("buf_free", wr_accept, 1'b1);
      u_ctl.cmd(RD, 2'h1, 13'h0001, 16'h0000, 2'h0);
      u_ctl.cmd(RD, 2'h1, 13'h0002, 16'h0000, 2'h0);
      look(2, 2'h0);
      check("buf_d1", dq_o, 16'hc3c3);
      look(1, 2'h0);
      check("buf_d2", dq_o, 16'h3c3c);
   endtask

   // Four-beat write cut by burst stop, read back, then a suspended read
   task automatic t_bst;
      u_ctl.mode(13'h0032);
      u_ctl.open(2'h3, 0);
      u_ctl.cmd(WR, 2'h3, 13'h0000, 16'h1111, 2'h0);
      u_ctl.idle(3, 2'h0);
      u_ctl.cmd(WR, 2'h3, 13'h0000, 16'h2222, 2'h0);
      u_ctl.idle(1, 2'h0);
      u_ctl.cmd(sdram_pkg::CMD_BST, 2'h3, 13'h0000, 16'h0000, 2'h0);
      u_ctl.cmd(RD, 2'h3, 13'h0000, 16'h0000, 2'h0);
      look(3, 2'h0);
      check("bst_d0", dq_o, 16'h2222);
      look(1, 2'h0);
      check("bst_d1", dq_o, 16'hdddd);
      look(1, 2'h0);
      check("bst_d2", dq_o, 16'h1111);
      look(1, 2'h0);
      check("bst_d3", dq_o, 16'heeee);
      u_ctl.cmd(RD, 2'h3, 13'h0000, 16'h0000, 2'h0);
      u_ctl.set_cke(1'b0);
      look(2, 2'h0);
      check("susp_on", suspended, 1'b1);
      check("susp_pd", power_down, 1'b0);
      u_ctl.set_cke(1'b1);
      look(2, 2'h0);
      check("susp_off", suspended, 1'b0);
      check("susp_data", dq_o, 16'h2222);
      check("susp_oe", dq_oe, 2'h3);
   endtask

   // Main sequence
   initial begin
      rstn = 1'b0;
      t_reset;
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      u_ctl.power_up;
      look(10, 2'h0); // Let the wake-up refresh finish first
      check("init_done", init_done, 1'b1);
      t_wr_rd;
      t_rd_mask;
      t_pre_cut(3'h3);
      t_pre_cut(3'h2);
      u_ctl.mode(13'h0030);
      t_cke;
      t_autopre;
      t_buffer;
      t_bst;
      stop_test;
   end

   // Watchdog well past the expected run length
   initial begin
      #320000;
      err_count++;
      stop_test;
   end
endmodule
